// ---- inc/dpu_regs.svh ----
// Constants of the data prefetch unit: instruction fields, codes, hints.
// Assumes 32-bit instruction words as delivered by the decode stage.
`ifndef DPU_REGS_SVH
`define DPU_REGS_SVH
// Instruction field positions
`define DPU_OPC_HI 31
`define DPU_OPC_LO 26
`define DPU_BASE_HI 25
`define DPU_BASE_LO 21
`define DPU_IDX_HI 20
`define DPU_IDX_LO 16
`define DPU_OHINT_HI 20
`define DPU_OHINT_LO 16
`define DPU_XHINT_HI 15
`define DPU_XHINT_LO 11
`define DPU_ZERO_HI 10
`define DPU_ZERO_LO 6
`define DPU_FUNC_HI 5
`define DPU_FUNC_LO 0
`define DPU_OFF_HI 15
`define DPU_OFF_LO 0
// Opcode values
`define DPU_OPC_OFFSET 6'h33
`define DPU_OPC_FPX 6'h13
`define DPU_FUNC_INDEXED 6'h0f
`define DPU_ZERO_FIELD 5'h00
// Hint values
`define DPU_HINT_LOAD 5'h00
`define DPU_HINT_STORE 5'h01
`define DPU_HINT_LOAD_STR 5'h04
`define DPU_HINT_STORE_STR 5'h05
`define DPU_HINT_LOAD_RET 5'h06
`define DPU_HINT_STORE_RET 5'h07
`define DPU_HINT_WB_INV 5'h19
`define DPU_HINT_ZERO_ALLOC 5'h1e
// Default value of the uncached attribute parameter
`define DPU_CCA_UNCACHED_DEF 3'h2
`endif

// ---- inc/dpu_pkg.sv ----
// Types shared by the data prefetch unit files.
// Assumes nothing beyond a SystemVerilog compiler.
package dpu_pkg;
    typedef enum logic [2:0] {
        DPU_ST_IDLE = 3'b000,
        DPU_ST_AGEN = 3'b001,
        DPU_ST_XLATE = 3'b010,
        DPU_ST_PROBE = 3'b011,
        DPU_ST_ISSUE = 3'b100
    } dpu_state_e;
    typedef enum logic [1:0] {
        DPU_OP_FILL_LOAD = 2'b00,
        DPU_OP_FILL_STORE = 2'b01,
        DPU_OP_WB_INV = 2'b10,
        DPU_OP_ZERO_ALLOC = 2'b11
    } dpu_dc_op_e;
    typedef enum logic [2:0] {
        DPU_EXC_NONE = 3'b000,
        DPU_EXC_CPU = 3'b001,
        DPU_EXC_RI = 3'b010,
        DPU_EXC_BUS = 3'b011,
        DPU_EXC_CACHE = 3'b100
    } dpu_exc_e;
endpackage

// ---- rtl/dpu_addr_gen.sv ----
// Effective address adder with a registered sum.
// Assumes the caller holds the operands valid in the cycle load_i is high.
`timescale 1ns/100ps
module dpu_addr_gen import dpu_pkg::*; #(
    parameter int ADDR_W = 32
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [ADDR_W-1:0] base_i,
    input wire logic [ADDR_W-1:0] addend_i,
    output logic [ADDR_W-1:0] sum_o
);
    typedef struct packed {
        logic [ADDR_W-1:0] sum;
    } dpu_agen_s;

    dpu_agen_s st_q, st_d;

    // ------------------------------------------------------------
    // Adder
    // ------------------------------------------------------------
    // Wraps modulo the address width; carry out is meaningless here
    always_comb begin
        st_d = st_q;
        if (load_i) begin
            st_d.sum = base_i + addend_i;
        end
    end

    // State register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sum_o = st_q.sum;
endmodule // dpu_addr_gen

// ---- rtl/dpu_prefetch_unit.sv ----
// Data prefetch unit: decodes prefetch instructions, forms the address,
// translates it as a data load and hands a hint to the data cache.
// Assumes the decode stage offers one request at a time while busy_o is
// low, and that the translation and cache ports answer with one-cycle acks.
`timescale 1ns/100ps
`include "dpu_regs.svh"
module dpu_prefetch_unit import dpu_pkg::*; #(
    parameter int ADDR_W = 32,
    parameter bit HAS_FPU = 1'b1,
    parameter bit REPORT_ERRORS = 1'b1,
    parameter logic [2:0] UNCACHED_CCA = `DPU_CCA_UNCACHED_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic [ADDR_W-1:0] base_data_i,
    input wire logic [ADDR_W-1:0] index_data_i,
    input wire logic cop1_usable_i,
    output logic busy_o,
    output logic done_o,
    output logic exc_valid_o,
    output logic [2:0] exc_code_o,
    output logic tlb_req_o,
    output logic [ADDR_W-1:0] tlb_vaddr_o,
    output logic tlb_refill_allow_o,
    input wire logic tlb_ack_i,
    input wire logic tlb_hit_i,
    input wire logic tlb_mapped_i,
    input wire logic tlb_addr_err_i,
    input wire logic [ADDR_W-1:0] tlb_paddr_i,
    input wire logic [2:0] tlb_cca_i,
    output logic dc_probe_o,
    output logic dc_req_o,
    output logic [1:0] dc_op_o,
    output logic [ADDR_W-1:0] dc_paddr_o,
    output logic dc_stream_o,
    output logic dc_retain_o,
    input wire logic dc_probe_ack_i,
    input wire logic dc_hit_i,
    input wire logic dc_locked_i,
    input wire logic dc_ack_i,
    input wire logic dc_bus_err_i,
    input wire logic dc_cache_err_i
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 16) begin : g_bad_width
        $error("dpu_prefetch_unit: ADDR_W must be at least 16");
    end

    typedef struct packed {
        dpu_state_e st;
        logic [ADDR_W-1:0] paddr;
        logic busy;
        logic done;
        logic exc_valid;
        dpu_exc_e exc_code;
        logic tlb_req;
        logic [ADDR_W-1:0] vaddr;
        logic refill_allow;
        logic dc_probe;
        logic dc_req;
        dpu_dc_op_e dc_op;
        logic stream;
        logic retain;
    } dpu_state_s;

    dpu_state_s st_q, st_d;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Sign-extend the 16-bit offset to the address width
    function automatic logic [ADDR_W-1:0] sext16(input logic [15:0] v);
        sext16 = {{(ADDR_W-16){v[15]}}, v};
    endfunction

    // Map a hint to a cache operation; valid low means no-operation
    function automatic logic [4:0] hint_map(input logic [4:0] h);
        // Packs {valid, stream, retain, op[1:0]}
        unique case (h)
            `DPU_HINT_LOAD: hint_map = {3'b100, DPU_OP_FILL_LOAD};
            `DPU_HINT_STORE: hint_map = {3'b100, DPU_OP_FILL_STORE};
            `DPU_HINT_LOAD_STR: hint_map = {3'b110, DPU_OP_FILL_LOAD};
            `DPU_HINT_STORE_STR: hint_map = {3'b110, DPU_OP_FILL_STORE};
            `DPU_HINT_LOAD_RET: hint_map = {3'b101, DPU_OP_FILL_LOAD};
            `DPU_HINT_STORE_RET: hint_map = {3'b101, DPU_OP_FILL_STORE};
            `DPU_HINT_WB_INV: hint_map = {3'b100, DPU_OP_WB_INV};
            `DPU_HINT_ZERO_ALLOC: hint_map = {3'b100, DPU_OP_ZERO_ALLOC};
            default: hint_map = 5'h00;
        endcase
    endfunction

    logic is_offset, is_indexed, is_fpx;
    logic [4:0] hint, hmap;
    logic [ADDR_W-1:0] addend, agen_sum;

    // Instruction classification
    assign is_offset = instr_i[`DPU_OPC_HI:`DPU_OPC_LO] == `DPU_OPC_OFFSET;
    assign is_fpx = instr_i[`DPU_OPC_HI:`DPU_OPC_LO] == `DPU_OPC_FPX;
    assign is_indexed = is_fpx
        && instr_i[`DPU_FUNC_HI:`DPU_FUNC_LO] == `DPU_FUNC_INDEXED
        && instr_i[`DPU_ZERO_HI:`DPU_ZERO_LO] == `DPU_ZERO_FIELD;
    // Hint sits in a different field for each form
    assign hint = is_indexed ? instr_i[`DPU_XHINT_HI:`DPU_XHINT_LO]
                             : instr_i[`DPU_OHINT_HI:`DPU_OHINT_LO];
    assign hmap = hint_map(hint);
    // Second operand: index register or signed offset
    assign addend = is_indexed ? index_data_i
                               : sext16(instr_i[`DPU_OFF_HI:`DPU_OFF_LO]);

    dpu_addr_gen #(
        .ADDR_W(ADDR_W)
    ) u_agen (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(st_q.st == DPU_ST_IDLE && req_valid_i),
        .base_i(base_data_i),
        .addend_i(addend),
        .sum_o(agen_sum)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Every exit path lands in IDLE with a one-cycle done pulse
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.exc_valid = 1'b0;
        st_d.exc_code = DPU_EXC_NONE;
        st_d.refill_allow = 1'b0; // Prefetch never refills
        unique case (st_q.st)
            DPU_ST_IDLE: begin
                if (req_valid_i) begin
                    st_d.dc_op = dpu_dc_op_e'(hmap[1:0]);
                    st_d.stream = hmap[3];
                    st_d.retain = hmap[2];
                    if (is_indexed && !HAS_FPU) begin
                        st_d.done = 1'b1;
                        st_d.exc_valid = 1'b1;
                        st_d.exc_code = DPU_EXC_RI;
                    end else if (is_indexed && !cop1_usable_i) begin
                        st_d.done = 1'b1;
                        st_d.exc_valid = 1'b1;
                        st_d.exc_code = DPU_EXC_CPU;
                    end else if (!is_offset && !is_indexed) begin
                        // Not a prefetch: unknown to this unit
                        st_d.done = 1'b1;
                        st_d.exc_valid = 1'b1;
                        st_d.exc_code = DPU_EXC_RI;
                    end else if (!hmap[4]) begin
                        st_d.done = 1'b1;
                    end else begin
                        st_d.busy = 1'b1;
                        st_d.st = DPU_ST_AGEN;
                    end
                end
            end
            DPU_ST_AGEN: begin
                st_d.vaddr = agen_sum;
                st_d.tlb_req = 1'b1;
                st_d.st = DPU_ST_XLATE;
            end
            DPU_ST_XLATE: begin
                if (tlb_ack_i) begin
                    st_d.tlb_req = 1'b0;
                    st_d.paddr = tlb_paddr_i;
                    // Faults and misses end silently
                    if (tlb_addr_err_i || (tlb_mapped_i && !tlb_hit_i)
                            || tlb_cca_i == UNCACHED_CCA) begin
                        st_d.done = 1'b1;
                        st_d.busy = 1'b0;
                        st_d.st = DPU_ST_IDLE;
                    end else begin
                        st_d.dc_probe = 1'b1;
                        st_d.st = DPU_ST_PROBE;
                    end
                end
            end
            DPU_ST_PROBE: begin
                if (dc_probe_ack_i) begin
                    st_d.dc_probe = 1'b0;
                    // Locked lines and zero-fill hits need no action
                    if (dc_locked_i
                            || (dc_hit_i
                            && st_q.dc_op == DPU_OP_ZERO_ALLOC)) begin
                        st_d.done = 1'b1;
                        st_d.busy = 1'b0;
                        st_d.st = DPU_ST_IDLE;
                    end else begin
                        st_d.dc_req = 1'b1;
                        st_d.st = DPU_ST_ISSUE;
                    end
                end
            end
            DPU_ST_ISSUE: begin
                if (dc_ack_i) begin
                    st_d.dc_req = 1'b0;
                    st_d.done = 1'b1;
                    st_d.busy = 1'b0;
                    st_d.st = DPU_ST_IDLE;
                    // Bus error takes priority over cache error
                    if (REPORT_ERRORS && dc_bus_err_i) begin
                        st_d.exc_valid = 1'b1;
                        st_d.exc_code = DPU_EXC_BUS;
                    end else if (REPORT_ERRORS && dc_cache_err_i) begin
                        st_d.exc_valid = 1'b1;
                        st_d.exc_code = DPU_EXC_CACHE;
                    end
                end
            end
            default: begin
                st_d = '0;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy_o = st_q.busy;
    assign done_o = st_q.done;
    assign exc_valid_o = st_q.exc_valid;
    assign exc_code_o = st_q.exc_code;
    assign tlb_req_o = st_q.tlb_req;
    assign tlb_vaddr_o = st_q.vaddr;
    assign tlb_refill_allow_o = st_q.refill_allow;
    assign dc_probe_o = st_q.dc_probe;
    assign dc_req_o = st_q.dc_req;
    assign dc_op_o = st_q.dc_op;
    assign dc_paddr_o = st_q.paddr;
    assign dc_stream_o = st_q.stream;
    assign dc_retain_o = st_q.retain;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic take;
    assign take = st_q.st == DPU_ST_IDLE && req_valid_i;

    AST_OFFSET_VADDR: assert property (
        take && is_offset && hmap[4] |-> ##2 tlb_req_o && tlb_vaddr_o ==
        $past(base_data_i, 2)
        + $past(sext16(instr_i[`DPU_OFF_HI:`DPU_OFF_LO]), 2))
        else $error("offset address wrong");
    AST_INDEX_VADDR: assert property (
        take && is_indexed && HAS_FPU && cop1_usable_i && hmap[4] |-> ##2
        tlb_vaddr_o == $past(base_data_i, 2) + $past(index_data_i, 2))
        else $error("indexed address wrong");
    AST_NO_ADDR_EXC: assert property (
        st_q.st == DPU_ST_XLATE && tlb_ack_i |=> !exc_valid_o)
        else $error("translation raised an exception");
    AST_ERR_REPORT: assert property (
        st_q.st == DPU_ST_ISSUE && dc_ack_i && dc_bus_err_i |=>
        done_o && exc_valid_o == REPORT_ERRORS)
        else $error("bus error reporting inconsistent");
    AST_LOCKED: assert property (
        st_q.st == DPU_ST_PROBE && dc_probe_ack_i && dc_locked_i |=>
        done_o && !dc_req_o ##1 !dc_req_o)
        else $error("locked line touched");
    AST_TLB_MISS: assert property (
        st_q.st == DPU_ST_XLATE && tlb_ack_i && tlb_mapped_i && !tlb_hit_i
        |=> done_o && !dc_probe_o && !tlb_refill_allow_o)
        else $error("fetch after translation miss");
    AST_UNCACHED: assert property (
        st_q.st == DPU_ST_XLATE && tlb_ack_i && tlb_cca_i == UNCACHED_CCA
        |=> !dc_probe_o && !dc_req_o && !busy_o)
        else $error("memory operation on uncached location");
    AST_NO_FPU: assert property (
        take && is_indexed && !HAS_FPU |=> exc_valid_o &&
        exc_code_o == DPU_EXC_RI)
        else $error("indexed form accepted without FPU");
    AST_COP_UNUSABLE: assert property (
        take && is_indexed && HAS_FPU && !cop1_usable_i |=> exc_valid_o &&
        exc_code_o == DPU_EXC_CPU)
        else $error("coprocessor unusable not raised");
    AST_ZERO_HIT: assert property (
        st_q.st == DPU_ST_PROBE && dc_probe_ack_i && dc_hit_i &&
        st_q.dc_op == DPU_OP_ZERO_ALLOC |=> !dc_req_o && done_o)
        else $error("zero-fill issued on a hit");
    AST_NOP_HINT: assert property (
        take && is_offset && !hmap[4] |=> done_o && !exc_valid_o && !busy_o)
        else $error("reserved hint not a no-operation");
    AST_ADDR_ERR: assert property (
        st_q.st == DPU_ST_XLATE && tlb_ack_i && tlb_addr_err_i |=>
        !dc_probe_o ##1 !dc_req_o)
        else $error("data moved after address error");

    COV_ZERO_ALLOC: cover property (
        dc_req_o && dc_op_o == DPU_OP_ZERO_ALLOC && dc_ack_i);
    COV_LOCKED: cover property (dc_probe_o && dc_probe_ack_i && dc_locked_i);
    COV_BUS_ERR: cover property (exc_valid_o && exc_code_o == DPU_EXC_BUS);
    COV_INDEXED_FILL: cover property (
        take && is_indexed ##[1:20] dc_req_o && dc_ack_i);
endmodule // dpu_prefetch_unit

// ---- tb/dpu_far_model.sv ----
// Far-side model: translation buffer and data cache answering the unit.
// Assumes level requests from the unit, held until their one-cycle ack.
`timescale 1ns/100ps
module dpu_far_model #(
    parameter logic [31:0] PA_XOR = 32'h8000_0000
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [11:0] cfg_i,
    input wire logic tlb_req_i,
    input wire logic [31:0] tlb_vaddr_i,
    input wire logic dc_probe_i,
    input wire logic dc_req_i,
    output logic tlb_ack_o,
    output logic tlb_hit_o,
    output logic tlb_mapped_o,
    output logic tlb_addr_err_o,
    output logic [31:0] tlb_paddr_o,
    output logic [2:0] tlb_cca_o,
    output logic dc_probe_ack_o,
    output logic dc_hit_o,
    output logic dc_locked_o,
    output logic dc_ack_o,
    output logic dc_bus_err_o,
    output logic dc_cache_err_o
);
    logic [1:0] wait_q;
    logic [31:0] junk_q;
    logic pend;
    // A request still waiting for its answer
    assign pend = (tlb_req_i && !tlb_ack_o) || (dc_probe_i && !dc_probe_ack_o)
                  || (dc_req_i && !dc_ack_o);
    // Acks are pulses after 0..3 stall cycles chosen by cfg_i[11:10]
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 2'h0;
            junk_q <= 32'h5a5a_a5a5;
            tlb_ack_o <= 1'b0;
            dc_probe_ack_o <= 1'b0;
            dc_ack_o <= 1'b0;
        end else begin
            junk_q <= junk_q + 32'h9e37_79b9;
            tlb_ack_o <= 1'b0;
            dc_probe_ack_o <= 1'b0;
            dc_ack_o <= 1'b0;
            if (pend && wait_q == cfg_i[11:10]) begin
                wait_q <= 2'h0;
                tlb_ack_o <= tlb_req_i;
                dc_probe_ack_o <= dc_probe_i;
                dc_ack_o <= dc_req_i;
            end else if (pend) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
    // Qualifiers hold only with their ack; elsewhere they churn so that a
    // late sample sees garbage instead of a lucky stale value
    assign tlb_hit_o = tlb_ack_o ? cfg_i[9] : junk_q[0];
    assign tlb_mapped_o = tlb_ack_o ? cfg_i[8] : junk_q[1];
    assign tlb_addr_err_o = tlb_ack_o ? cfg_i[7] : junk_q[2];
    assign tlb_cca_o = tlb_ack_o ? cfg_i[6:4] : junk_q[5:3];
    assign tlb_paddr_o = tlb_ack_o ? (tlb_vaddr_i ^ PA_XOR) : junk_q;
    assign dc_hit_o = dc_probe_ack_o ? cfg_i[3] : junk_q[6];
    assign dc_locked_o = dc_probe_ack_o ? cfg_i[2] : junk_q[7];
    assign dc_bus_err_o = dc_ack_o ? cfg_i[1] : junk_q[8];
    assign dc_cache_err_o = dc_ack_o ? cfg_i[0] : junk_q[9];
endmodule // dpu_far_model

// ---- tb/tb.sv ----
// Testbench of the data prefetch unit: notes the expected outcome of each
// request in a queue and checks it when the unit signals completion.
// Assumes dpu_far_model stands in for translation buffer and data cache.
`timescale 1ns/100ps
`include "dpu_regs.svh"
module tb import dpu_pkg::*;;
    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    localparam logic [31:0] PA_XOR = 32'h8000_0000;
    typedef struct packed {
        logic xl;
        logic pr;
        logic iss;
        logic [1:0] op;
        logic [1:0] sr;
        logic [2:0] exc;
        logic [31:0] va;
    } dpu_note_s;
    dpu_note_s notes[$];
    int error_cnt = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h9267;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic [31:0] instr_i = 32'h0;
    logic [31:0] base_data_i = 32'h0;
    logic [31:0] index_data_i = 32'h0;
    logic cop1_usable_i = 1'b1;
    logic [11:0] far_cfg = 12'h330;
    logic busy_o, done_o, exc_valid_o, tlb_req_o, tlb_refill_allow_o;
    logic dc_probe_o, dc_req_o, dc_stream_o, dc_retain_o;
    logic [2:0] exc_code_o, tlb_cca_i;
    logic [1:0] dc_op_o;
    logic [31:0] tlb_vaddr_o, dc_paddr_o, tlb_paddr_i, seen_va, seen_pa;
    logic tlb_ack_i, tlb_hit_i, tlb_mapped_i, tlb_addr_err_i, dc_probe_ack_i;
    logic dc_hit_i, dc_locked_i, dc_ack_i, dc_bus_err_i, dc_cache_err_i;
    logic seen_xl = 1'b0;
    logic seen_pr = 1'b0;
    logic seen_iss = 1'b0;
    logic [3:0] seen_op;

    always #25 core_clk_i = ~core_clk_i;

    dpu_prefetch_unit dut (.core_clk_i, .rst_n_i, .req_valid_i, .instr_i,
        .base_data_i, .index_data_i, .cop1_usable_i, .busy_o, .done_o,
        .exc_valid_o, .exc_code_o, .tlb_req_o, .tlb_vaddr_o,
        .tlb_refill_allow_o, .tlb_ack_i, .tlb_hit_i, .tlb_mapped_i,
        .tlb_addr_err_i, .tlb_paddr_i, .tlb_cca_i, .dc_probe_o, .dc_req_o,
        .dc_op_o, .dc_paddr_o, .dc_stream_o, .dc_retain_o, .dc_probe_ack_i,
        .dc_hit_i, .dc_locked_i, .dc_ack_i, .dc_bus_err_i, .dc_cache_err_i);

    dpu_far_model #(.PA_XOR(PA_XOR)) far (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .cfg_i(far_cfg), .tlb_req_i(tlb_req_o),
        .tlb_vaddr_i(tlb_vaddr_o), .dc_probe_i(dc_probe_o),
        .dc_req_i(dc_req_o), .tlb_ack_o(tlb_ack_i), .tlb_hit_o(tlb_hit_i),
        .tlb_mapped_o(tlb_mapped_i), .tlb_addr_err_o(tlb_addr_err_i),
        .tlb_paddr_o(tlb_paddr_i), .tlb_cca_o(tlb_cca_i),
        .dc_probe_ack_o(dc_probe_ack_i), .dc_hit_o(dc_hit_i),
        .dc_locked_o(dc_locked_i), .dc_ack_o(dc_ack_i),
        .dc_bus_err_o(dc_bus_err_i), .dc_cache_err_o(dc_cache_err_i));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Works out the outcome, notes it, then offers the request once
    task automatic run(input logic [31:0] ins, input logic [31:0] b,
                       input logic [31:0] x, input logic [11:0] c,
                       input logic cu);
        dpu_note_s n;
        dpu_exc_e pre;
        logic [4:0] h;
        logic fpx;
        int k;
        fpx = ins[31:26] == `DPU_OPC_FPX;
        h = fpx ? ins[15:11] : ins[20:16];
        n.va = fpx ? b + x : b + {{16{ins[15]}}, ins[15:0]};
        pre = (!fpx && ins[31:26] != `DPU_OPC_OFFSET) ? DPU_EXC_RI
            : (fpx && ins[10:0] != 11'h00f) ? DPU_EXC_RI
            : (fpx && !cu) ? DPU_EXC_CPU : DPU_EXC_NONE;
        n.xl = pre == DPU_EXC_NONE && h inside {5'h00, 5'h01, 5'h04, 5'h05,
            5'h06, 5'h07, 5'h19, 5'h1e};
        n.pr = n.xl && !c[7] && !(c[8] && !c[9]) && c[6:4] != 3'h2;
        n.iss = n.pr && !c[2] && !(c[3] && h == 5'h1e);
        n.op = h == 5'h1e ? 2'h3 : h == 5'h19 ? 2'h2 : {1'b0, h[0]};
        n.sr = {h[4:1] == 4'h2, h[4:1] == 4'h3};
        n.exc = pre != DPU_EXC_NONE ? pre : (n.iss && c[1]) ? DPU_EXC_BUS
            : (n.iss && c[0]) ? DPU_EXC_CACHE : DPU_EXC_NONE;
        k = 0;
        @(negedge core_clk_i);
        while (busy_o !== 1'b0 && k < 100) begin
            @(negedge core_clk_i);
            k++;
        end
        if (k >= 100) begin
            error_cnt++;
            give_verdict();
        end
        notes.push_back(n);
        @(posedge core_clk_i);
        req_valid_i <= 1'b1;
        instr_i <= ins;
        base_data_i <= b;
        index_data_i <= x;
        far_cfg <= c;
        cop1_usable_i <= cu;
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Monitor: gathers what the unit did and checks at completion
    // ------------------------------------------------------------
    always @(negedge core_clk_i) begin
        dpu_note_s n;
        if (tlb_req_o === 1'b1) begin
            seen_xl = 1'b1;
            seen_va = tlb_vaddr_o;
            check("busy", 32'h1, busy_o);
        end
        if (dc_probe_o === 1'b1) begin
            seen_pr = 1'b1;
        end
        if (dc_req_o === 1'b1) begin
            seen_iss = 1'b1;
            seen_pa = dc_paddr_o;
            seen_op = {dc_op_o, dc_stream_o, dc_retain_o};
        end
        if (done_o === 1'b1) begin
            n = notes.pop_front();
            check("translate", n.xl, seen_xl);
            if (n.xl) check("vaddr", n.va, seen_va);
            check("probe", n.pr, seen_pr);
            check("issue", n.iss, seen_iss);
            if (n.iss) check("paddr", n.va ^ PA_XOR, seen_pa);
            if (n.iss) check("op", {n.op, n.sr}, seen_op);
            check("exception", {n.exc != 3'h0, n.exc},
                  {exc_valid_o, exc_code_o});
            check("refill", 32'h0, tlb_refill_allow_o);
            check("idle", 32'h0, busy_o);
            seen_xl = 1'b0;
            seen_pr = 1'b0;
            seen_iss = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        static logic [11:0] cfgs [10] = '{12'h130, 12'h030, 12'h3b0, 12'h320,
            12'h334, 12'h338, 12'h332, 12'h331, 12'h333, 12'hf30};
        logic [31:0] r;
        int k;
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        // Every hint on both forms, negative offset, cached miss
        for (int h = 0; h < 32; h++) begin
            run({6'h33, 5'h1, 5'(h), 16'h8004}, rnd(), 32'h0, 12'h330, 1'b1);
            run({6'h13, 10'h0, 5'(h), 11'h00f}, rnd(), rnd(), 12'h330, 1'b1);
        end
        // Translation and cache outcomes, load and zero-fill hints
        foreach (cfgs[i]) begin
            run({6'h33, 10'h0, 16'hfff0}, rnd(), 32'h0, cfgs[i], 1'b1);
            run({6'h33, 5'h0, 5'h1e, 16'h0010}, rnd(), 32'h0, cfgs[i], 1'b1);
        end
        // Refused encodings
        run({6'h13, 10'h0, 5'h0, 11'h00f}, rnd(), rnd(), 12'h330, 1'b0);
        run({6'h13, 10'h0, 5'h0, 11'h00e}, rnd(), rnd(), 12'h330, 1'b1);
        run({6'h13, 10'h0, 5'h0, 11'h04f}, rnd(), rnd(), 12'h330, 1'b1);
        run({6'h0d, 26'h0}, rnd(), rnd(), 12'h330, 1'b1);
        // Random legal requests with random far-side answers
        for (int i = 0; i < 80; i++) begin
            r = rnd();
            if (r[31]) begin
                run({6'h13, r[25:11], 11'h00f}, rnd(), rnd(), r[11:0], r[30]);
            end else begin
                run({6'h33, r[25:0]}, rnd(), rnd(), r[11:0], r[30]);
            end
        end
        k = 0;
        while (notes.size() != 0 && k < 200) begin
            @(posedge core_clk_i);
            k++;
        end
        if (k >= 200) error_cnt++;
        give_verdict();
    end

    // Cuts a hang short
    initial begin
        repeat (30000) @(posedge core_clk_i);
        error_cnt++;
        give_verdict();
    end
endmodule // tb
